/* verilog/tcs_pkg.sv */
// package for the temperature conversion sequencer
// assumes a 20 MHz pclk and an apb master with 32-bit data
package tcs_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONFIG1   = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h0c;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h10;
    localparam logic [7:0] OFS_TEMP0     = 8'h20; // +4*channel
    localparam logic [7:0] OFS_ALERT0    = 8'h40; // +4*channel
    localparam logic [7:0] OFS_OVERT0    = 8'h60; // +4*channel
    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int FAST1_BIT  = 4;
    localparam int HALT_BIT   = 6;
    localparam int NUM_CH     = 7;
    // channel indices: 0..5 remote 1..6, 6 local
    localparam logic [2:0] CH_LOCAL = 3'h6;
    // overtemp capable channels (remote 1,4,5,6 -> idx 0,3,4,5)
    localparam logic [6:0] OVT_CAPABLE = 7'h39;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CONFIG1 = 8'h00;
    localparam logic [7:0] RST_TEMP    = 8'h00;
    localparam logic [7:0] RST_ALERT   = 8'h55;
    localparam logic [7:0] RST_OVERTEMP_OUT_N   = 8'h6e;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 20_000_000;
    localparam int TIMEOUT_MS      = 45;
    localparam int TIMEOUT_CYC     = (CLK_HZ / 1000) * TIMEOUT_MS;
    localparam int CONV_CYC        = 64;
    // irq status bits
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_ALERT = 1;
    localparam int IRQ_OVERTEMP_OUT_N = 2;
    localparam int IRQ_TOUT  = 3;
endpackage

/* verilog/tcs_order.sv */
// channel order generator for the conversion sequencer
// assumes the caller advances it only after a conversion completes
`timescale 1ns/100ps
module tcs_order (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       restart,
    input  wire logic       advance,
    input  wire logic       fast1,
    output logic [2:0]      channel
);
    // ------------------------------------------------------------
    // round robin position and interleave phase
    // ------------------------------------------------------------
    logic [2:0] pos_ff;   // index into default order
    logic       one_ff;   // fast mode: next slot is channel 1
    logic [2:0] nxt_pos;

    // default order: remote 1-3, local, remote 4-6
    function automatic logic [2:0] slot_ch(input logic [2:0] p);
        unique case (p)
            3'h0: slot_ch = 3'h0;
            3'h1: slot_ch = 3'h1;
            3'h2: slot_ch = 3'h2;
            3'h3: slot_ch = tcs_pkg::CH_LOCAL;
            3'h4: slot_ch = 3'h3;
            3'h5: slot_ch = 3'h4;
            3'h6: slot_ch = 3'h5;
            default: slot_ch = 3'h0;
        endcase
    endfunction

    // fast mode skips slot 0 since channel 1 runs in between
    always_comb begin
        nxt_pos = (pos_ff == 3'h6) ? (fast1 ? 3'h1 : 3'h0)
                                   : pos_ff + 3'h1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_ff <= 3'h0;
            one_ff <= 1'b0;
        end else if (restart) begin
            pos_ff <= 3'h0;
            one_ff <= 1'b0;
        end else if (advance) begin
            if (fast1 && !one_ff && pos_ff == 3'h0) begin
                pos_ff <= 3'h1;
            end else if (fast1 && !one_ff) begin
                one_ff <= 1'b1;
            end else begin
                one_ff <= 1'b0;
                pos_ff <= nxt_pos;
            end
        end
    end

    // first slot is channel 1 in both modes; then interleave
    assign channel = one_ff ? 3'h0 : slot_ch(pos_ff);
endmodule

/* verilog/tcs_top.sv */
// conversion sequencer and alarm logic, apb register slave
// assumes an adc that answers adc_done with adc_data per start
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/100ps
module tcs_top #(
    parameter int TIMEOUT_CYCLES = tcs_pkg::TIMEOUT_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             adc_start,
    output logic [2:0]       adc_channel,
    input  wire logic        adc_done,
    input  wire logic [7:0]  adc_data,
    input  wire logic        bus_scl_low,
    input  wire logic        bus_start_seen,
    output logic             bus_if_reset,
    output logic             overtemp_out_n_o,
    output logic             overtemp_out_n_oe,
    output logic             alert_out_n_o,
    output logic             alert_out_n_oe,
    output logic             irq
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0]  config1_ff;
    logic [7:0]  temp_ff   [tcs_pkg::NUM_CH];
    logic [7:0]  alert_ff  [tcs_pkg::NUM_CH];
    logic [7:0]  overtemp_out_n_ff  [tcs_pkg::NUM_CH];
    logic [3:0]  irq_stat_ff;
    logic [3:0]  irq_en_ff;
    logic        busy_ff;
    logic        tout_en_ff;
    logic [31:0] tout_cnt_ff;
    logic        halt_q_ff;
    logic [31:0] nxt_prdata;
    logic [3:0]  irq_set;
    logic [6:0]  alert_hit;
    logic [6:0]  overtemp_out_n_hit;
    logic        wr_en;
    logic        rd_en;
    logic        halt;
    logic        fast1;
    logic        restart;
    logic        conv_fin;
    logic [2:0]  seq_ch;
    logic        tout_fire;

    assign halt   = config1_ff[tcs_pkg::HALT_BIT];
    assign fast1  = config1_ff[tcs_pkg::FAST1_BIT];
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && !penable && !pwrite;
    assign pready = 1'b1;   // zero wait state, also in standby
    assign restart  = halt_q_ff && !halt;
    assign conv_fin = busy_ff && adc_done && !halt;

    // region match for per-channel registers
    function automatic logic in_bank(input logic [7:0] a,
                                     input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        in_bank = (a >= base) && (d[7:2] < 6'(tcs_pkg::NUM_CH))
                  && (d[1:0] == 2'b00);
    endfunction

    // unmapped or misaligned addresses answer an error
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            pslverr = !(paddr == tcs_pkg::OFS_CONFIG1 ||
                        paddr == tcs_pkg::OFS_STATUS  ||
                        paddr == tcs_pkg::OFS_IRQ_STAT ||
                        paddr == tcs_pkg::OFS_IRQ_EN  ||
                        paddr == tcs_pkg::OFS_IRQ_CLR ||
                        in_bank(paddr, tcs_pkg::OFS_TEMP0)  ||
                        in_bank(paddr, tcs_pkg::OFS_ALERT0) ||
                        in_bank(paddr, tcs_pkg::OFS_OVERT0));
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    tcs_order u_order (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (restart),
        .advance (conv_fin),
        .fast1   (fast1),
        .channel (seq_ch)
    );

    // start a conversion whenever idle, not halted and not in the restart cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_ff     <= 1'b0;
            adc_start   <= 1'b0;
            adc_channel <= 3'h0;
        end else begin
            adc_start <= 1'b0;
            if (halt) begin
                busy_ff <= 1'b0;
            end else if (!busy_ff && !restart) begin
                busy_ff     <= 1'b1;
                adc_start   <= 1'b1;
                adc_channel <= seq_ch;
            end else if (conv_fin) begin
                busy_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_q_ff <= 1'b0;
        end else begin
            halt_q_ff <= halt;
        end
    end

    // results land only when not halted, so an abort keeps old data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < tcs_pkg::NUM_CH; i++) begin
                temp_ff[i] <= tcs_pkg::RST_TEMP;
            end
        end else if (conv_fin) begin
            temp_ff[adc_channel] <= adc_data;
        end
    end

    // ------------------------------------------------------------
    // thresholds and alarm pins
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < tcs_pkg::NUM_CH; g++) begin : g_cmp
            assign alert_hit[g] = temp_ff[g] > alert_ff[g];
            assign overtemp_out_n_hit[g] = tcs_pkg::OVT_CAPABLE[g] &&
                                  (temp_ff[g] > overtemp_out_n_ff[g]);
        end
    endgenerate

    // open drain: only ever drive low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overtemp_out_n_oe <= 1'b0;
            alert_out_n_oe    <= 1'b0;
        end else begin
            overtemp_out_n_oe <= |overtemp_out_n_hit;
            alert_out_n_oe    <= |alert_hit;
        end
    end
    assign overtemp_out_n_o = 1'b0;
    assign alert_out_n_o    = 1'b0;

    // ------------------------------------------------------------
    // bus timeout
    // ------------------------------------------------------------
    assign tout_fire = tout_en_ff && bus_scl_low &&
                       (tout_cnt_ff >= 32'(TIMEOUT_CYCLES));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tout_en_ff <= 1'b1;
        end else if (bus_start_seen) begin
            tout_en_ff <= 1'b1;
        end else if (halt && !halt_q_ff) begin
            tout_en_ff <= 1'b0;
        end
    end

    // count low time; a reset pulse also restarts the count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tout_cnt_ff  <= 32'h0;
            bus_if_reset <= 1'b0;
        end else begin
            bus_if_reset <= tout_fire;
            if (!bus_scl_low || !tout_en_ff || tout_fire) begin
                tout_cnt_ff <= 32'h0;
            end else begin
                tout_cnt_ff <= tout_cnt_ff + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // registers written by software
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config1_ff <= tcs_pkg::RST_CONFIG1;
            irq_en_ff  <= 4'h0;
        end else if (wr_en && !pslverr) begin
            if (paddr == tcs_pkg::OFS_CONFIG1) begin
                config1_ff <= pwdata[7:0];
            end
            if (paddr == tcs_pkg::OFS_IRQ_EN) begin
                irq_en_ff <= pwdata[3:0];
            end
        end
    end

    // alert on all seven, overtemp stored only where capable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < tcs_pkg::NUM_CH; i++) begin
                alert_ff[i] <= tcs_pkg::RST_ALERT;
                overtemp_out_n_ff[i] <= tcs_pkg::RST_OVERTEMP_OUT_N;
            end
        end else if (wr_en && !pslverr) begin
            for (int i = 0; i < tcs_pkg::NUM_CH; i++) begin
                if (paddr == tcs_pkg::OFS_ALERT0 + 8'(4 * i)) begin
                    alert_ff[i] <= pwdata[7:0];
                end
                if (paddr == tcs_pkg::OFS_OVERT0 + 8'(4 * i) &&
                    tcs_pkg::OVT_CAPABLE[i]) begin
                    overtemp_out_n_ff[i] <= pwdata[7:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status: set wins over clear
    // ------------------------------------------------------------
    assign irq_set = {tout_fire, |overtemp_out_n_hit, |alert_hit, conv_fin};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= 4'h0;
        end else begin
            irq_stat_ff <= (irq_stat_ff &
                            ~((wr_en && paddr == tcs_pkg::OFS_IRQ_CLR)
                              ? pwdata[3:0] : 4'h0)) | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_ff & irq_en_ff);
        end
    end

    // ------------------------------------------------------------
    // read data, captured in setup so it stands in access phase
    // ------------------------------------------------------------
    always_comb begin
        nxt_prdata = 32'h0;
        if (paddr == tcs_pkg::OFS_CONFIG1) begin
            nxt_prdata = {24'h0, config1_ff};
        end else if (paddr == tcs_pkg::OFS_STATUS) begin
            nxt_prdata = {9'h0, overtemp_out_n_hit, 1'b0, alert_hit,
                          tout_en_ff, adc_channel,
                          2'h0, halt, busy_ff};
        end else if (paddr == tcs_pkg::OFS_IRQ_STAT) begin
            nxt_prdata = {28'h0, irq_stat_ff};
        end else if (paddr == tcs_pkg::OFS_IRQ_EN) begin
            nxt_prdata = {28'h0, irq_en_ff};
        end
        for (int i = 0; i < tcs_pkg::NUM_CH; i++) begin
            if (paddr == tcs_pkg::OFS_TEMP0 + 8'(4 * i)) begin
                nxt_prdata = {24'h0, temp_ff[i]};
            end
            if (paddr == tcs_pkg::OFS_ALERT0 + 8'(4 * i)) begin
                nxt_prdata = {24'h0, alert_ff[i]};
            end
            if (paddr == tcs_pkg::OFS_OVERT0 + 8'(4 * i)) begin
                nxt_prdata = tcs_pkg::OVT_CAPABLE[i]
                             ? {24'h0, overtemp_out_n_ff[i]} : 32'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            prdata <= nxt_prdata;
        end
    end
endmodule

/* tb/tcs_top_properties.sv */
// port checker for the conversion sequencer
// assumes it is bound into tcs_top with one pclk domain
`timescale 1ns/100ps
module tcs_props #(
    parameter int TIMEOUT_CYCLES = 20
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        adc_start,
    input wire logic [2:0]  adc_channel,
    input wire logic        adc_done,
    input wire logic        bus_scl_low,
    input wire logic        bus_start_seen,
    input wire logic        bus_if_reset,
    input wire logic        overtemp_out_n_o,
    input wire logic        overtemp_out_n_oe,
    input wire logic        alert_out_n_o,
    input wire logic        alert_out_n_oe
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ------
    // helper state
    // ------
    logic cfg_wr;
    logic halt_ff;
    logic off_ff;
    int   low_ff;
    assign cfg_wr = psel && penable && pwrite && pready && paddr == 8'h00;
    // halt mirror; start condition wins over entering standby
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_ff <= 1'b0;
            off_ff  <= 1'b0;
        end else begin
            if (cfg_wr) begin
                halt_ff <= pwdata[6];
            end
            if (bus_start_seen) begin
                off_ff <= 1'b0;
            end else if (cfg_wr && pwdata[6] && !halt_ff) begin
                off_ff <= 1'b1;
            end
        end
    end
    // run length of the low serial clock, never saturates in a short run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_ff <= 0;
        end else begin
            low_ff <= bus_scl_low ? low_ff + 1 : 0;
        end
    end
    // ------
    // assertions
    // ------
    chk_overtemp_out_n_drive: assert property (
        overtemp_out_n_oe |-> !overtemp_out_n_o)
        else $error("overtemp pin driven high");
    chk_alert_drive: assert property (
        alert_out_n_oe |-> !alert_out_n_o)
        else $error("alert pin driven high");
    chk_start_single: assert property (
        adc_start |=> !adc_start)
        else $error("start pulse longer than one cycle");
    chk_chan_hold: assert property (
        $changed(adc_channel) |-> adc_start)
        else $error("channel moved without a start");
    chk_done_next: assert property (
        adc_done && !halt_ff && !psel |-> ##2 adc_start)
        else $error("no start after conversion done");
    chk_halt_quiet: assert property (
        halt_ff && $past(halt_ff) |-> !adc_start)
        else $error("conversion started in standby");
    chk_tout_count: assert property (
        bus_if_reset |-> low_ff >= TIMEOUT_CYCLES)
        else $error("interface reset before timeout");
    chk_tout_off: assert property (
        off_ff && $past(off_ff) |-> !bus_if_reset)
        else $error("interface reset while timeout off");
    chk_bus_alive: assert property (
        psel && penable |-> pready)
        else $error("bus access not answered");
    // main scenarios reached
    cover property (adc_done && halt_ff);
    cover property (bus_if_reset);
    cover property (alert_out_n_oe && overtemp_out_n_oe);
endmodule
bind tcs_top tcs_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .adc_start, .adc_channel, .adc_done, .bus_scl_low, .bus_start_seen,
    .bus_if_reset, .overtemp_out_n_o, .overtemp_out_n_oe, .alert_out_n_o,
    .alert_out_n_oe
);

/* tb/tcs_adc_model.sv */
// behavioural converter answering the sequencer
// assumes adc_start is a one-cycle pulse on pclk
`timescale 1ns/100ps
module tcs_adc_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        adc_start,
    input  wire logic [2:0]  adc_channel,
    input  wire logic [55:0] temp_tab,
    input  wire logic        slow,
    output logic             adc_done,
    output logic [7:0]       adc_data
);
    logic [2:0] ch_ff;
    logic [4:0] cnt_ff;
    // one result per start; data toggles outside done so stale never matches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch_ff    <= 3'h0;
            cnt_ff   <= 5'h0;
            adc_done <= 1'b0;
            adc_data <= 8'h00;
        end else begin
            adc_done <= cnt_ff == 5'h1;
            adc_data <= cnt_ff == 5'h1 ? temp_tab[8*ch_ff+:8] : ~adc_data;
            if (adc_start) begin
                ch_ff  <= adc_channel;
                cnt_ff <= slow ? 5'h14 : 5'h3;
            end else if (cnt_ff != 5'h0) begin
                cnt_ff <= cnt_ff - 5'h1;
            end
        end
    end
endmodule

/* tb/tcs_top_bench.sv */
// self-checking bench for the conversion sequencer
// assumes the checker is bound in and pclk at 20 MHz
`timescale 1ns/100ps
module tcs_top_bench;
    logic        pclk = 1'b0;
    logic        presetn;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        adc_start;
    logic [2:0]  adc_channel;
    logic        adc_done;
    logic [7:0]  adc_data;
    logic        bus_scl_low = 1'b0;
    logic        bus_start_seen = 1'b0;
    logic        bus_if_reset;
    logic        overtemp_out_n_o;
    logic        overtemp_out_n_oe;
    logic        alert_out_n_o;
    logic        alert_out_n_oe;
    logic        irq;
    logic [55:0] temp_tab = 56'h36_35_34_33_32_31_30;
    logic        slow = 1'b0;
    logic [31:0] rd;
    logic        err;
    logic [2:0]  seq[$];
    logic [2:0]  order[7] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h3, 3'h4, 3'h5};
    int          error_cnt = 0;
    int          checks_done = 0;
    int          resets = 0;
    tcs_top #(.TIMEOUT_CYCLES(20)) dut (.*);
    tcs_adc_model u_adc (.*);
    // clock and watchdog, far above the expected run length
    always #25 pclk = ~pclk;
    initial begin
        #(50 * 40000);
        error_cnt++;
        close_out();
    end
    // record every start and interface reset
    always @(posedge pclk) begin
        if (adc_start === 1'b1) seq.push_back(adc_channel);
        if (bus_if_reset === 1'b1) resets++;
    end
    // ------
    // tasks
    // ------
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp(rd, e);
    endtask
    task automatic starts(input int n);
        int k;
        k = 0;
        while (seq.size() < n && k < 5000) begin
            k++;
            @(posedge pclk);
        end
        if (seq.size() < n) begin
            error_cnt++;
            $display("unexpected at %0t: too few starts", $time);
        end
    endtask
    // settle in standby long enough to drain a conversion, then resume
    task automatic restart(input logic [31:0] cfg);
        apb(1'b1, 8'h00, cfg | 32'h40);
        repeat (30) @(posedge pclk);
        seq.delete();
        apb(1'b1, 8'h00, cfg);
    endtask
    task automatic close_out();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ------
    // main sequence
    // ------
    initial begin
        // nba at time zero gives the async reset a real falling edge
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdc(8'h00, 32'h0);
        rdc(8'h58, 32'h55);
        rdc(8'h60, 32'h6e);
        apb(1'b1, 8'h64, 32'h0);
        rdc(8'h64, 32'h0);
        rdc(8'h1c, 32'h0);
        cmp(32'(err), 32'h1);
        restart(32'h0);
        starts(14);
        for (int i = 0; i < 14; i++) cmp(32'(seq[i]), 32'(order[i % 7]));
        for (int i = 0; i < 7; i++) rdc(8'(8'h20 + 4 * i), 32'h30 + i);
        restart(32'h10);
        starts(12);
        for (int i = 0; i < 12; i++)
            cmp(32'(seq[i]), i % 2 ? 32'(order[(i+1)/2]) : 32'h0);
        restart(32'h0);
        apb(1'b1, 8'h48, 32'h32);
        starts(8);
        cmp(32'(alert_out_n_oe), 32'h0);
        apb(1'b1, 8'h48, 32'h31);
        apb(1'b1, 8'h6c, 32'h32);
        seq.delete();
        starts(8);
        cmp(32'(alert_out_n_oe), 32'h1);
        cmp(32'(overtemp_out_n_oe), 32'h1);
        // earlier standby entries left the timeout off; a start re-arms it
        bus_start_seen <= 1'b1;
        @(posedge pclk);
        bus_start_seen <= 1'b0;
        bus_scl_low <= 1'b1;
        repeat (30) @(posedge pclk);
        bus_scl_low <= 1'b0;
        cmp(resets, 32'h1);
        slow <= 1'b1;
        seq.delete();
        starts(1);
        temp_tab <= 56'h46_45_44_43_42_41_40;
        apb(1'b1, 8'h00, 32'h40);
        repeat (60) @(posedge pclk);
        cmp(seq.size(), 32'h1);
        rdc(8'(8'h20 + 4 * seq[0]), 32'h30 + seq[0]);
        rdc(8'h48, 32'h31);
        apb(1'b1, 8'h0c, 32'h1);
        repeat (2) @(posedge pclk);
        cmp(32'(irq), 32'h1);
        apb(1'b1, 8'h0c, 32'h0);
        repeat (2) @(posedge pclk);
        cmp(32'(irq), 32'h0);
        apb(1'b1, 8'h0c, 32'h1);
        apb(1'b1, 8'h10, 32'h1);
        repeat (2) @(posedge pclk);
        cmp(32'(irq), 32'h0);
        resets = 0;
        bus_scl_low <= 1'b1;
        repeat (40) @(posedge pclk);
        bus_scl_low <= 1'b0;
        cmp(resets, 32'h0);
        bus_start_seen <= 1'b1;
        @(posedge pclk);
        bus_start_seen <= 1'b0;
        bus_scl_low <= 1'b1;
        repeat (30) @(posedge pclk);
        bus_scl_low <= 1'b0;
        cmp(resets, 32'h1);
        close_out();
    end
endmodule
